// *** hw/baud_timer.v ***
// Eight-bit auto-reload baud timer with hidden receive copy
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module baud_timer (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       run_i,
   input  wire [2:0] src_sel_i,
   input  wire [7:0] reload_i,
   input  wire       low_wr_i,
   input  wire [7:0] low_wdata_i,
   input  wire       ext_osc_i,
   input  wire       ext_pin_i,
   input  wire       rx_restart_i,
   output wire [7:0] low_count_o,
   output wire       tx_ovf_o,
   output wire       rx_ovf_o
);
   wire [1:0] async_in;   // Pins from outside the clock domain
   wire [1:0] sync_out;   // Synchronised copies
   reg  [1:0] sync_prev_q;// Previous synchronised level
   reg  [1:0] div4_q;     // Prescaler by four
   reg  [3:0] div12_q;    // Prescaler by twelve
   reg  [5:0] div48_q;    // Prescaler by forty-eight
   reg  [2:0] osc8_q;     // Oscillator edge divider by eight
   reg  [7:0] low_q;      // Transmit side counter
   reg  [7:0] rxc_q;      // Hidden receive side counter
   reg        tick;       // Timer count enable
   wire       osc_rise;
   wire       pin_rise;
   assign async_in = {ext_pin_i, ext_osc_i};
   // Two flip-flop synchroniser per external input
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg s1_q;
         reg s2_q;
         always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= async_in[gi];
               s2_q <= s1_q;
            end
         end
         assign sync_out[gi] = s2_q;
      end
   endgenerate
   assign osc_rise = sync_out[0] & ~sync_prev_q[0];
   assign pin_rise = sync_out[1] & ~sync_prev_q[1];
   // Prescalers run freely
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_prev_q <= 2'h0;
         div4_q      <= 2'h0;
         div12_q     <= 4'h0;
         div48_q     <= 6'h0;
         osc8_q      <= 3'h0;
      end else begin
         sync_prev_q <= sync_out;
         div4_q      <= div4_q + 2'h1;
         div12_q     <= (div12_q == `DIV12_END) ? 4'h0 : div12_q + 4'h1;
         div48_q     <= (div48_q == `DIV48_END) ? 6'h0 : div48_q + 6'h1;
         if (osc_rise)
            osc8_q <= osc8_q + 3'h1;
      end
   end
   // Count enable from the six selectable sources
   always @* begin
      case (src_sel_i)
         `SEL_DIV1:   tick = 1'b1;
         `SEL_DIV4:   tick = (div4_q == `DIV4_END);
         `SEL_DIV12:  tick = (div12_q == `DIV12_END);
         `SEL_DIV48:  tick = (div48_q == `DIV48_END);
         `SEL_OSC8:   tick = osc_rise & (osc8_q == `OSC8_END);
         `SEL_EXTPIN: tick = pin_rise;
         default:     tick = 1'b0;
      endcase
   end
   // Overflow from all-ones, period is 256 minus reload
   assign tx_ovf_o = run_i & tick & (low_q == `CNT_MAX);
   assign rx_ovf_o = run_i & tick & (rxc_q == `CNT_MAX) & ~rx_restart_i;
   assign low_count_o = low_q;
   // Both counters reload from the same value
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_q <= `RLD_RST;
         rxc_q <= `RLD_RST;
      end else begin
         if (low_wr_i)
            low_q <= low_wdata_i;
         else if (tx_ovf_o)
            low_q <= reload_i;
         else if (run_i & tick)
            low_q <= low_q + 8'h01;
         // Start bit forces a reload of the hidden copy
         if (rx_restart_i)
            rxc_q <= reload_i;
         else if (rx_ovf_o)
            rxc_q <= reload_i;
         else if (run_i & tick)
            rxc_q <= rxc_q + 8'h01;
      end
   end
endmodule // baud_timer
`default_nettype wire

// *** hw/uart_regs.vh ***
// Register map, field positions and constants of the serial port
`ifndef UART_REGS_VH
`define UART_REGS_VH
// Byte offsets on the register bus
`define OFF_CTRL      8'h00
`define OFF_DATA      8'h04
`define OFF_TIMER     8'h08
`define OFF_STATUS    8'h0c
`define OFF_MASK      8'h10
`define OFF_LOWCNT    8'h14
// Control register fields
`define CTRL_MODE     7
`define CTRL_MCE      5
`define CTRL_REN      4
`define CTRL_TB8      3
`define CTRL_RB8      2
`define MODE_RST      1'b0
// Status and mask fields
`define ST_RXD        0
`define ST_TXD        1
`define ST_RST        2'h0
// Timer register fields
`define TMR_RUN       16
`define TMR_SEL_HI    10
`define TMR_SEL_LO    8
`define TMR_RLD_HI    7
`define TMR_RLD_LO    0
`define RLD_RST       8'h00
`define SEL_RST       3'h0
// Timer clock source codes
`define SEL_DIV1      3'h0
`define SEL_DIV4      3'h1
`define SEL_DIV12     3'h2
`define SEL_DIV48     3'h3
`define SEL_OSC8      3'h4
`define SEL_EXTPIN    3'h5
// Prescaler terminal counts
`define DIV4_END      2'h3
`define DIV12_END     4'hb
`define DIV48_END     6'h2f
`define OSC8_END      3'h7
// Timer limit
`define CNT_MAX       8'hff
// Bit indices within a frame: stop, ninth, data and start
`define LAST_8BIT     4'h9
`define LAST_9BIT     4'ha
`define NINTH_IDX     4'h9
`define FIRST_DATA    4'h1
`define LAST_DATA     4'h8
`define START_IDX     4'h0
`endif

// *** hw/uart_top.v ***
// Full-duplex serial port with APB registers and timer baud source
// Operation
// - Independent full-duplex TX/RX, modes 1 and 3
// - Received byte buffered while next shifts in
// - Data writes load transmit holding register only
// - Data reads return receive buffer only
// - Interrupt when either done flag sets
// - Flags stay set until software clears
// - Baud from eight-bit auto-reload timer
// - TX from low counter, RX hidden copy
// - Each overflow stream divided by two
// - Hidden counter runs, shares reload value
// - Start bit forces hidden counter reload
// - Six selectable timer clock sources
// - Overflow rate clock over 256 minus reload
// - Eight-bit frame, stop into ninth bit
// - Nine-bit frame, ninth stored, stop ignored
// - Load buffer only if flag clear, check
// - TX done set at stop bit start
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire        pready_o,
   output wire [31:0] prdata_o,
   output wire        pslverr_o,
   input  wire        rx_i,
   output wire        tx_o,
   input  wire        ext_osc_i,
   input  wire        baud_timer_ext_input_i,
   output wire        irq_o
);
   // Transmit and receive state codes
   localparam TX_IDLE = 1'b0;
   localparam TX_BUSY = 1'b1;
   localparam RX_IDLE = 1'b0;
   localparam RX_BITS = 1'b1;

   // Software visible state
   reg        frame_mode_q;       // Nine-bit frames when set
   reg        mce_q;              // Multiprocessor check enable
   reg        ren_q;              // Receiver enable
   reg        tb8_q;              // Transmit ninth bit
   reg        rb8_q;              // Received ninth bit
   reg        tx_done_q;          // Sticky transmit done
   reg        rx_done_q;          // Sticky receive done
   reg  [1:0] mask_q;             // Interrupt mask
   reg        run_q;              // Timer run
   reg  [2:0] sel_q;              // Timer clock source
   reg  [7:0] reload_q;           // Timer reload value
   reg  [7:0] rx_buf_q;           // Buffered receive byte
   reg  [7:0] tx_hold_q;          // Transmit holding register
   // Bus outputs
   reg  [31:0] prdata_q;          // Read data
   reg         pslverr_q;         // Unmapped access flag
   reg  [31:0] rd_mux;            // Read data selection
   reg         addr_ok;           // Address decodes to a register
   // Transmitter
   reg         tx_state_q;        // Transmit state
   reg         tx_pend_q;         // Holding register full
   reg         tx_half_q;         // Overflow divider by two
   reg  [9:0]  tx_sh_q;           // Bits still to send
   reg  [3:0]  tx_cnt_q;          // Index of bit on the line
   reg         tx_q;              // Line output
   // Receiver
   reg         rx_s1_q;           // Synchroniser first stage
   reg         rx_s2_q;           // Synchroniser second stage
   reg         rx_prev_q;         // Previous line level
   reg         rx_state_q;        // Receive state
   reg         rx_half_q;         // Overflow divider by two
   reg  [3:0]  rx_cnt_q;          // Index of bit being sampled
   reg  [7:0]  rx_sh_q;           // Receive shift register
   reg         rx_b9_q;           // Captured ninth bit
   // Decoded strobes
   wire        setup;
   wire        wr_en;
   wire        wr_ctrl;
   wire        wr_data;
   wire        wr_timer;
   wire        wr_status;
   wire        wr_mask;
   wire        wr_low;
   wire [7:0]  ctrl_rd;
   wire [7:0]  low_count;
   wire        tx_ovf;
   wire        rx_ovf;
   wire        tx_baud;
   wire        rx_start;
   wire        rx_sample;
   wire [3:0]  last_idx;
   wire        tx_set;
   reg         rx_set;
   reg         rx_chk;

   // APB decode: one wait-free access phase
   assign setup     = psel_i & ~penable_i;
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign wr_ctrl   = wr_en & (paddr_i == `OFF_CTRL);
   assign wr_data   = wr_en & (paddr_i == `OFF_DATA);
   assign wr_timer  = wr_en & (paddr_i == `OFF_TIMER);
   assign wr_status = wr_en & (paddr_i == `OFF_STATUS);
   assign wr_mask   = wr_en & (paddr_i == `OFF_MASK);
   assign wr_low    = wr_en & (paddr_i == `OFF_LOWCNT);
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_q;
   assign pslverr_o = pslverr_q;

   // Control register image, unused bit reads one
   assign ctrl_rd = {frame_mode_q, 1'b1, mce_q, ren_q,
                     tb8_q, rb8_q, tx_done_q, rx_done_q};

   // Read multiplexer and address check
   always @* begin
      rd_mux  = 32'h0;
      addr_ok = 1'b1;
      case (paddr_i)
         `OFF_CTRL:   rd_mux[7:0] = ctrl_rd;
         `OFF_DATA:   rd_mux[7:0] = rx_buf_q;
         `OFF_TIMER: begin
            rd_mux[`TMR_RLD_HI:`TMR_RLD_LO] = reload_q;
            rd_mux[`TMR_SEL_HI:`TMR_SEL_LO] = sel_q;
            rd_mux[`TMR_RUN]                = run_q;
         end
         `OFF_STATUS: rd_mux[1:0] = {tx_done_q, rx_done_q};
         `OFF_MASK:   rd_mux[1:0] = mask_q;
         `OFF_LOWCNT: rd_mux[7:0] = low_count;
         default:     addr_ok = 1'b0;  // Unmapped reads zero
      endcase
   end

   // Read data and error captured in the setup cycle
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= pwrite_i ? 32'h0 : rd_mux;
         pslverr_q <= ~addr_ok;
      end
   end

   // Software configuration registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_mode_q <= `MODE_RST;
         mce_q        <= 1'b0;
         ren_q        <= 1'b0;
         tb8_q        <= 1'b0;
         mask_q       <= `ST_RST;
         run_q        <= 1'b0;
         sel_q        <= `SEL_RST;
         reload_q     <= `RLD_RST;
      end else begin
         if (wr_ctrl) begin
            frame_mode_q <= pwdata_i[`CTRL_MODE];
            mce_q        <= pwdata_i[`CTRL_MCE];
            ren_q        <= pwdata_i[`CTRL_REN];
            tb8_q        <= pwdata_i[`CTRL_TB8];
         end
         if (wr_mask)
            mask_q <= pwdata_i[1:0];
         if (wr_timer) begin
            run_q    <= pwdata_i[`TMR_RUN];
            sel_q    <= pwdata_i[`TMR_SEL_HI:`TMR_SEL_LO];
            reload_q <= pwdata_i[`TMR_RLD_HI:`TMR_RLD_LO];
         end
      end
   end

   // Baud timer with hidden receive copy
   baud_timer u_timer (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .run_i        (run_q),
      .src_sel_i    (sel_q),
      .reload_i     (reload_q),
      .low_wr_i     (wr_low),
      .low_wdata_i  (pwdata_i[7:0]),
      .ext_osc_i    (ext_osc_i),
      .ext_pin_i    (baud_timer_ext_input_i),
      .rx_restart_i (rx_start),
      .low_count_o  (low_count),
      .tx_ovf_o     (tx_ovf),
      .rx_ovf_o     (rx_ovf)
   );

   // Stop bit index by frame mode
   assign last_idx = frame_mode_q ? `LAST_9BIT : `LAST_8BIT;
   // Every second transmit overflow is one bit time
   assign tx_baud  = tx_ovf & tx_half_q;
   // Done flag raised as the stop bit starts
   assign tx_set   = tx_baud & (tx_state_q == TX_BUSY) &
                     ((tx_cnt_q + 4'h1) == last_idx);

   // Transmit divider, holding register and shifter
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_half_q  <= 1'b0;
         tx_pend_q  <= 1'b0;
         tx_hold_q  <= 8'h0;
         tx_state_q <= TX_IDLE;
         tx_sh_q    <= 10'h3ff;
         tx_cnt_q   <= `START_IDX;
         tx_q       <= 1'b1;
      end else begin
         if (tx_ovf)
            tx_half_q <= ~tx_half_q;
         if (tx_baud) begin
            case (tx_state_q)
               TX_IDLE: begin
                  if (tx_pend_q) begin
                     tx_pend_q  <= 1'b0;
                     tx_state_q <= TX_BUSY;
                     tx_q       <= 1'b0;
                     tx_cnt_q   <= `START_IDX;
                     // Data LSB first, then ninth and stop
                     tx_sh_q    <= {1'b1, frame_mode_q ? tb8_q : 1'b1, tx_hold_q};
                  end
               end
               TX_BUSY: begin
                  if (tx_cnt_q == last_idx) begin
                     // Stop bit over, chain a pending byte
                     if (tx_pend_q) begin
                        tx_pend_q <= 1'b0;
                        tx_q      <= 1'b0;
                        tx_cnt_q  <= `START_IDX;
                        tx_sh_q   <= {1'b1, frame_mode_q ? tb8_q : 1'b1, tx_hold_q};
                     end else begin
                        tx_state_q <= TX_IDLE;
                     end
                  end else begin
                     tx_q     <= tx_sh_q[0];
                     tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                     tx_cnt_q <= tx_cnt_q + 4'h1;
                  end
               end
               default: tx_state_q <= TX_IDLE;
            endcase
         end
         // A write always reaches the holding register
         if (wr_data) begin
            tx_hold_q <= pwdata_i[7:0];
            tx_pend_q <= 1'b1;
         end
      end
   end
   assign tx_o = tx_q;

   // Receive line synchroniser and edge history
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_s1_q   <= 1'b1;
         rx_s2_q   <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_s1_q   <= rx_i;
         rx_s2_q   <= rx_s1_q;
         rx_prev_q <= rx_s2_q;
      end
   end

   // Falling edge while idle and enabled is a start
   assign rx_start  = ren_q & run_q & (rx_state_q == RX_IDLE) &
                      rx_prev_q & ~rx_s2_q;
   // First overflow is mid start bit, then every second one
   assign rx_sample = rx_ovf & ~rx_half_q & (rx_state_q == RX_BITS);

   // Acceptance test at the end of a frame
   always @* begin
      rx_chk = frame_mode_q ? rx_b9_q : rx_s2_q;
      rx_set = rx_sample & (rx_cnt_q == last_idx) &
               ~rx_done_q & (~mce_q | rx_chk);
   end

   // Receive shifter, independent of the transmitter
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_q <= RX_IDLE;
         rx_half_q  <= 1'b0;
         rx_cnt_q   <= `START_IDX;
         rx_sh_q    <= 8'h0;
         rx_b9_q    <= 1'b0;
         rx_buf_q   <= 8'h0;
      end else begin
         if (rx_start) begin
            rx_state_q <= RX_BITS;
            rx_half_q  <= 1'b0;
            rx_cnt_q   <= `START_IDX;
         end else if (rx_ovf) begin
            rx_half_q <= ~rx_half_q;
         end
         case (rx_state_q)
            RX_IDLE: begin
            end
            RX_BITS: begin
               if (~ren_q) begin
                  rx_state_q <= RX_IDLE;  // Receiver disabled mid-frame
               end else if (rx_sample) begin
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if ((rx_cnt_q == `START_IDX) & rx_s2_q)
                     rx_state_q <= RX_IDLE;  // Glitch, not a start bit
                  else if ((rx_cnt_q >= `FIRST_DATA) & (rx_cnt_q <= `LAST_DATA))
                     rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};  // LSB first
                  else if (frame_mode_q & (rx_cnt_q == `NINTH_IDX))
                     rx_b9_q <= rx_s2_q;
                  if (rx_cnt_q == last_idx)
                     rx_state_q <= RX_IDLE;
                  // Only the buffer is visible to software
                  if (rx_set)
                     rx_buf_q <= rx_sh_q;
               end
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // Ninth bit: stop bit or ninth data bit, or software write
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         rb8_q <= 1'b0;
      else if (rx_set)
         rb8_q <= rx_chk;
      else if (wr_ctrl)
         rb8_q <= pwdata_i[`CTRL_RB8];
   end

   // Sticky done flags, write one to clear, set wins
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_done_q <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         if (tx_set)
            tx_done_q <= 1'b1;
         else if (wr_status & pwdata_i[`ST_TXD])
            tx_done_q <= 1'b0;
         if (rx_set)
            rx_done_q <= 1'b1;
         else if (wr_status & pwdata_i[`ST_RXD])
            rx_done_q <= 1'b0;
      end
   end

   // Shared interrupt request from unmasked flags
   assign irq_o = |({tx_done_q, rx_done_q} & mask_q);

endmodule // uart_top
`default_nettype wire

// *** testbench/uart_peer.sv ***
// Far-side serial node model
`timescale 1ns/1ps
`default_nettype none
module uart_peer (
   input  wire logic clk_i,
   input  wire logic line_in_i,
   output var  logic line_out_o
);
   int         bit_clks = 4;  // Clocks per bit
   logic       nine = 1'b0;   // Ninth bit in frame
   logic [8:0] got;           // Last byte and ninth bit
   logic       stp;           // Last stop level
   int         cnt = 0;       // Frames decoded
   initial line_out_o = 1'b1;
   // Sends one frame LSB first, then idles
   task automatic send(input logic [7:0] b, input logic n9, input logic st);
      logic [10:0] f;
      f = nine ? {st, n9, b, 1'b0} : {1'b1, st, b, 1'b0};
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         line_out_o <= f[i];
         repeat (bit_clks) @(posedge clk_i);
      end
      line_out_o <= 1'b1;
   endtask
   // Decodes frames at mid-bit
   always begin
      @(negedge line_in_i);
      repeat (bit_clks / 2) @(negedge clk_i);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         repeat (bit_clks) @(negedge clk_i);
         got[i] = line_in_i;
      end
      repeat (bit_clks) @(negedge clk_i);
      stp = line_in_i;
      cnt++;
   end
endmodule // uart_peer
`default_nettype wire

// *** testbench/uart_top_asserts.sv ***
// Port assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_top_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        tx_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Setup, write strobe, mapped address
   wire su = psel_i && !penable_i;
   wire wa = psel_i && penable_i && pwrite_i;
   wire mp = paddr_i <= `OFF_LOWCNT && paddr_i[1:0] == 2'h0;
   wire ck = wa && (paddr_i == `OFF_STATUS || paddr_i == `OFF_MASK);
   property p_ready; psel_i && penable_i |-> pready_o; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   property p_unmap; su && !mp |=> pslverr_o && prdata_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_map; su && mp |=> !pslverr_o; endproperty
   a_map: assert property (p_map) else $error("mapped err");
   property p_hold; psel_i && penable_i |=> $stable(prdata_o); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_ctrl;
      su && !pwrite_i && paddr_i == `OFF_CTRL |=> prdata_o[31:6] == 26'h1 || prdata_o[31:6] == 26'h3;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl bits");
   property p_dat; su && !pwrite_i && paddr_i == `OFF_DATA |=> prdata_o[31:8] == 24'h0; endproperty
   a_dat: assert property (p_dat) else $error("data width");
   property p_start; $fell(tx_o) |=> !tx_o; endproperty
   a_start: assert property (p_start) else $error("short bit");
   property p_mask; wa && paddr_i == `OFF_MASK && pwdata_i[1:0] == 2'h0 |=> !irq_o; endproperty
   a_mask: assert property (p_mask) else $error("masked irq");
   property p_stick; irq_o && !ck |=> irq_o; endproperty
   a_stick: assert property (p_stick) else $error("irq dropped");
   c_tx: cover property ($fell(tx_o));
   c_irq: cover property ($rose(irq_o));
   c_err: cover property (su && !mp);
endmodule // uart_top_asserts
bind uart_top uart_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .tx_o(tx_o),
   .irq_o(irq_o));
`default_nettype wire

// *** testbench/uart_top_tb.sv ***
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_top_tb;
   logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, se;
   logic [1:0]  tk;            // Divider for external ticks
   logic [7:0]  paddr_i, b1, b2;
   logic [31:0] pwdata_i, rd;
   wire         pready_o, pslverr_o, tx_o, irq_o, rx_w;
   wire  [31:0] prdata_o;
   int          err_total, num_checks, k, n;
   int          len_t [6] = '{6, 16, 24, 96, 64, 8};
   logic [7:0]  rl_t [6] = '{8'hfd, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
   uart_top DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .rx_i(rx_w), .tx_o(tx_o),
      .ext_osc_i(tk[1]), .baud_timer_ext_input_i(tk[1]), .irq_o(irq_o));
   uart_peer peer (.clk_i(clk_i), .line_in_i(tx_o), .line_out_o(rx_w));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) tk <= tk + 2'h1;
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask
   task automatic bail;
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      test_done();
   endtask
   // One APB transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int m;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      m = 0;
      do begin
         @(posedge clk_i);
         m++;
      end while (pready_o !== 1'b1 && m < 20);
      rd = prdata_o;
      se = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (m >= 20) bail();
      @(posedge clk_i);
   endtask
   // Counts falling edges until tx_o is v
   task automatic tx_until(input logic v);
      k = 0;
      while (tx_o !== v && k < 3000) begin
         @(negedge clk_i);
         k++;
      end
      if (k >= 3000) bail();
   endtask
   task automatic wait_peer(input int c);
      k = 0;
      while (peer.cnt == c && k < 3000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 3000) bail();
   endtask
   // Peer frame at random phase, then status read
   task automatic rx_one(input logic [7:0] b, input logic n9, input logic st);
      repeat ($urandom_range(7)) @(posedge clk_i);
      peer.send(b, n9, st);
      repeat (12) @(posedge clk_i);
      apb(1'b0, `OFF_STATUS, 32'h0);
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      bail();
   end
   initial begin
      {rst_i, tk, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 45'h0};
      err_total = 0;
      num_checks = 0;
      void'($urandom(32'hf106));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 7; a++) begin
         apb(1'b0, 8'(a * 4), 32'h0);
         chk(rd, a == 0 ? 32'h40 : 32'h0, "reset");
         chk(32'(se), a == 6 ? 1 : 0, "slverr");
      end
      $display("registers done");
      apb(1'b1, `OFF_TIMER, 32'h1_00fe);
      apb(1'b1, `OFF_MASK, 32'h3);
      apb(1'b1, `OFF_CTRL, 32'h10);
      for (int i = 0; i < 5; i++) begin
         b1 = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom);
         n = peer.cnt;
         apb(1'b1, `OFF_DATA, {24'h0, b1});
         tx_until(1'b0);
         k = 0;
         while (irq_o !== 1'b1 && k < 99) begin
            @(negedge clk_i);
            k++;
         end
         chk(k, 36, "tx done");
         wait_peer(n);
         chk({23'h0, peer.stp, peer.got[7:0]}, {24'h1, b1}, "tx frame");
         apb(1'b0, `OFF_STATUS, 32'h0);
         chk(rd, 32'h2, "tx flag kept");
         apb(1'b1, `OFF_STATUS, 32'h2);
         chk(32'(irq_o), 0, "irq cleared");
         apb(1'b0, `OFF_DATA, 32'h0);
         chk(rd, 32'h0, "rx kept");
      end
      $display("transmit done");
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      rx_one(b1, 1'b0, 1'b1);
      chk(rd, 32'h1, "rx flag");
      chk(32'(irq_o), 1, "rx irq");
      rx_one(b2, 1'b0, 1'b1);
      apb(1'b0, `OFF_DATA, 32'h0);
      chk(rd, {24'h0, b1}, "overrun keeps");
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rd, 32'h55, "stop in ninth");
      apb(1'b1, `OFF_STATUS, 32'h1);
      fork
         peer.send(b2, 1'b0, 1'b1);
         begin
            repeat (20) @(posedge clk_i);
            apb(1'b0, `OFF_DATA, 32'h0);
            chk(rd, {24'h0, b1}, "held");
         end
      join
      repeat (12) @(posedge clk_i);
      apb(1'b0, `OFF_DATA, 32'h0);
      chk(rd, {24'h0, b2}, "second byte");
      apb(1'b1, `OFF_STATUS, 32'h1);
      apb(1'b1, `OFF_CTRL, 32'h30);
      rx_one(8'h5a, 1'b0, 1'b0);
      chk(rd, 32'h0, "bad stop");
      rx_one(8'h3c, 1'b0, 1'b1);
      chk(rd, 32'h1, "good stop");
      apb(1'b1, `OFF_STATUS, 32'h1);
      $display("receive done");
      peer.nine = 1'b1;
      apb(1'b1, `OFF_CTRL, 32'hb8);
      rx_one(b1, 1'b0, 1'b1);
      chk(rd, 32'h0, "data dropped");
      rx_one(b1, 1'b1, 1'b1);
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk(rd, 32'hfd, "addr taken");
      apb(1'b1, `OFF_STATUS, 32'h1);
      apb(1'b1, `OFF_CTRL, 32'h98);
      n = peer.cnt;
      fork
         peer.send(b1, 1'b0, 1'b1);
         apb(1'b1, `OFF_DATA, {24'h0, b2});
      join
      repeat (12) @(posedge clk_i);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rd, 32'h3, "both flags");
      wait_peer(n);
      chk(32'(peer.got), {23'h1, b2}, "ninth sent");
      apb(1'b0, `OFF_DATA, 32'h0);
      chk(rd, {24'h0, b1}, "ninth data");
      apb(1'b1, `OFF_MASK, 32'h0);
      chk(32'(irq_o), 0, "masked");
      apb(1'b1, `OFF_STATUS, 32'h3);
      $display("ninth bit done");
      peer.nine = 1'b0;
      apb(1'b1, `OFF_CTRL, 32'h10);
      apb(1'b1, `OFF_MASK, 32'h2);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `OFF_TIMER, {15'h0, 1'b1, 5'h0, 3'(i), rl_t[i]});
         apb(1'b1, `OFF_DATA, 32'h1);
         tx_until(1'b0);
         tx_until(1'b1);
         chk(k, len_t[i], "bit time");
         k = 0;
         while (irq_o !== 1'b1 && k < 3000) begin
            @(posedge clk_i);
            k++;
         end
         if (k >= 3000) bail();
         repeat (2 * len_t[i]) @(posedge clk_i);
         apb(1'b1, `OFF_STATUS, 32'h2);
      end
      $display("rates done");
      test_done();
   end
endmodule // uart_top_tb
`default_nettype wire
